// ==== rtl/eeo_pkg.sv ====
package eeo_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] EEO_IDX_OFFSET = 16'h5ECB;
  localparam logic [15:0] EEO_IDX_PPR    = 16'h5ECC;
  localparam logic [15:0] EEO_IDX_CTRL   = 16'h5ECD;
  localparam logic [15:0] EEO_IDX_STAT   = 16'h5ECE;

  localparam logic [15:0] EEO_OFFSET_RST = 16'h0000;
  localparam logic [15:0] EEO_PPR_RST    = 16'h0400;
  localparam logic [15:0] EEO_PPR_MIN    = 16'h0032;
  localparam logic [15:0] EEO_PPR_MAX    = 16'h0400;

  // control register fields
  localparam int          EEO_CTRL_SENSOR_LSB = 0;
  localparam int          EEO_CTRL_ENABLE_BIT = 2;
  localparam logic [2:0]  EEO_CTRL_RST        = 3'h4;

  // status register fields
  localparam int          EEO_STAT_COUNT_LSB = 0;
  localparam int          EEO_STAT_A_BIT     = 16;
  localparam int          EEO_STAT_B_BIT     = 17;
  localparam int          EEO_STAT_Z_BIT     = 18;

  // quarter-step position counter
  localparam int          EEO_QW        = 12;
  localparam int          EEO_MW        = 13;
  localparam int          EEO_PROD_W    = 27;
  localparam int          EEO_PROD_LSB  = 14;
  localparam logic [EEO_QW-1:0] EEO_Q_ZERO = 12'h000;
  localparam logic [EEO_QW-1:0] EEO_Q_ONE  = 12'h001;

  typedef enum logic [1:0] {
    resolver_sensor_option    = 2'b00,
    sine_cosine_sensor_option = 2'b01,
    hires_incremental_option  = 2'b10,
    absolute_sensor_option    = 2'b11
  } eeo_sensor_e;

  // digitised sine-period state of a sine-type sensor
  typedef struct packed {
    logic [1:0] quad;
    logic       index;
  } eeo_sense_s;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } eeo_enc_s;

endpackage

// ==== rtl/eeo_encoder_emulation_output.sv ====
// Behaviour
// R1: resolver mode emits configured pulses per revolution
// R2: pulse count held within 50..1024, reset 1024
// R3: pulse count used only with resolver sensor
// R4: sine sensors give one pulse per sine period
// R5: index moved by configured offset, default zero
// R6: software keeps offset below pulse count
// R7: index offset used only with resolver sensor
// R8: sine-cosine or absolute sensor: no index pulse
// R9: high-resolution incremental: native index, unshifted
// R10: controller may count edges for 2x or 4x
// R11: quadrature A/B, direction order, one index per turn
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module eeo_encoder_emulation_output (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [17:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  input  wire logic [15:0]          resolver_angle,
  input  wire eeo_pkg::eeo_sense_s  sensor_in,
  output eeo_pkg::eeo_enc_s         enc_out
);

  logic [15:0]              offset_q;
  logic [15:0]              ppr_q;
  logic [2:0]               ctrl_q;
  logic                     ack_q;
  logic [31:0]              rdat_q;
  logic [eeo_pkg::EEO_QW-1:0] cur_q;
  logic [eeo_pkg::EEO_QW-1:0] cur_d;
  eeo_pkg::eeo_enc_s        enc_q;

  eeo_pkg::eeo_sensor_e     sensor;
  logic                     enable;
  logic                     req;
  logic [15:0]              widx;
  logic [15:0]              wr_off;
  logic [15:0]              wr_ppr;
  logic [15:0]              wr_ppr_clamped;
  logic [2:0]               wr_ctrl;
  logic                     offset_ok;
  // write lanes are bytes, as the bus select bits count them
  localparam int            LANE_W = 8;

  assign sensor   = eeo_pkg::eeo_sensor_e'(ctrl_q[eeo_pkg::EEO_CTRL_SENSOR_LSB +: 2]);
  assign enable   = ctrl_q[eeo_pkg::EEO_CTRL_ENABLE_BIT];
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign widx     = wb_adr_i[17:2];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign enc_out  = enc_q;

  // byte-lane merge of the write data into each register
  for (genvar g = 0; g < $bits(offset_q) / LANE_W; g++) begin : g_lane
    assign wr_off[g*LANE_W +: LANE_W] = wb_sel_i[g] ?
                                        wb_dat_i[g*LANE_W +: LANE_W] :
                                        offset_q[g*LANE_W +: LANE_W];
    assign wr_ppr[g*LANE_W +: LANE_W] = wb_sel_i[g] ?
                                        wb_dat_i[g*LANE_W +: LANE_W] :
                                        ppr_q[g*LANE_W +: LANE_W];
  end
  assign wr_ctrl = wb_sel_i[0] ? wb_dat_i[2:0] : ctrl_q;

  // out-of-range counts are pulled to the nearest legal limit
  always_comb begin
    if (wr_ppr < eeo_pkg::EEO_PPR_MIN) begin
      wr_ppr_clamped = eeo_pkg::EEO_PPR_MIN; // [R2]
    end else if (wr_ppr > eeo_pkg::EEO_PPR_MAX) begin
      wr_ppr_clamped = eeo_pkg::EEO_PPR_MAX; // [R2]
    end else begin
      wr_ppr_clamped = wr_ppr;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      offset_q <= eeo_pkg::EEO_OFFSET_RST; // [R5]
      ppr_q    <= eeo_pkg::EEO_PPR_RST;    // [R2]
      ctrl_q   <= eeo_pkg::EEO_CTRL_RST;
    end else if (req && wb_we_i) begin
      if (widx == eeo_pkg::EEO_IDX_OFFSET) begin
        offset_q <= wr_off;
      end
      if (widx == eeo_pkg::EEO_IDX_PPR) begin
        ppr_q <= wr_ppr_clamped; // [R2]
      end
      if (widx == eeo_pkg::EEO_IDX_CTRL) begin
        ctrl_q <= wr_ctrl;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      rdat_q <= 32'h0000_0000;
      unique case (widx)
        eeo_pkg::EEO_IDX_OFFSET: rdat_q[15:0] <= offset_q;
        eeo_pkg::EEO_IDX_PPR:    rdat_q[15:0] <= ppr_q;
        eeo_pkg::EEO_IDX_CTRL:   rdat_q[2:0]  <= ctrl_q;
        eeo_pkg::EEO_IDX_STAT: begin
          rdat_q[eeo_pkg::EEO_STAT_COUNT_LSB +: eeo_pkg::EEO_QW] <= cur_q;
          rdat_q[eeo_pkg::EEO_STAT_A_BIT] <= enc_q.a;
          rdat_q[eeo_pkg::EEO_STAT_B_BIT] <= enc_q.b;
          rdat_q[eeo_pkg::EEO_STAT_Z_BIT] <= enc_q.z;
        end
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // resolver: quarter-step count per turn is four times the pulse count
  logic [eeo_pkg::EEO_PROD_W-1:0] prod;
  logic [eeo_pkg::EEO_MW-1:0]     modulus;
  logic [eeo_pkg::EEO_MW-1:0]     tgt;
  logic [eeo_pkg::EEO_MW-1:0]     cur13;
  logic [eeo_pkg::EEO_MW-1:0]     fwd;
  logic [eeo_pkg::EEO_MW-1:0]     off_quarter;

  assign prod    = eeo_pkg::EEO_PROD_W'(resolver_angle) *
                   eeo_pkg::EEO_PROD_W'(ppr_q[10:0]); // [R1] [R3]
  assign modulus = {ppr_q[10:0], 2'b00};
  assign tgt     = {1'b0, prod[eeo_pkg::EEO_PROD_LSB +: eeo_pkg::EEO_QW]};
  assign cur13   = {1'b0, cur_q};
  assign off_quarter = {offset_q[10:0], 2'b00};
  // offsets past the turn would alias in the quarter count: no index then
  assign offset_ok   = (offset_q < ppr_q); // [R5]

  // one quarter step per clock along the shorter way round the turn
  always_comb begin
    fwd   = (tgt >= cur13) ? tgt - cur13 : tgt + modulus - cur13;
    cur_d = cur_q;
    if (cur13 >= modulus) begin
      cur_d = eeo_pkg::EEO_Q_ZERO;
    end else if (fwd == '0) begin
      cur_d = cur_q;
    end else if (fwd <= {1'b0, modulus[eeo_pkg::EEO_MW-1:1]}) begin
      if (cur13 == modulus - 13'h0001) begin
        cur_d = eeo_pkg::EEO_Q_ZERO; // [R1]
      end else begin
        cur_d = cur_q + eeo_pkg::EEO_Q_ONE; // [R11]
      end
    end else begin
      if (cur_q == eeo_pkg::EEO_Q_ZERO) begin
        cur_d = eeo_pkg::EEO_QW'(modulus - 13'h0001); // [R1]
      end else begin
        cur_d = cur_q - eeo_pkg::EEO_Q_ONE; // [R11]
      end
    end
  end

  // the follower may lag the angle by a few steps at high speed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_q <= eeo_pkg::EEO_Q_ZERO;
    end else if (sensor == eeo_pkg::resolver_sensor_option) begin
      cur_q <= cur_d; // [R3]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enc_q <= '0;
    end else if (!enable) begin
      enc_q <= '0;
    end else begin
      unique case (sensor)
        eeo_pkg::resolver_sensor_option: begin
          enc_q.a <= cur_q[1]; // [R11]
          enc_q.b <= cur_q[1] ^ cur_q[0]; // [R11]
          enc_q.z <= offset_ok && (cur13 == off_quarter); // [R5] [R7]
        end
        eeo_pkg::hires_incremental_option: begin
          enc_q.a <= sensor_in.quad[1]; // [R4]
          enc_q.b <= sensor_in.quad[1] ^ sensor_in.quad[0]; // [R4]
          enc_q.z <= sensor_in.index; // [R9]
        end
        eeo_pkg::sine_cosine_sensor_option,
        eeo_pkg::absolute_sensor_option: begin
          enc_q.a <= sensor_in.quad[1]; // [R4]
          enc_q.b <= sensor_in.quad[1] ^ sensor_in.quad[0]; // [R4]
          enc_q.z <= 1'b0; // [R8]
        end
      endcase
    end
  end

  a_ppr_range: assert property ( // [R2]
    @(posedge clk) disable iff (!rstn)
    (ppr_q >= eeo_pkg::EEO_PPR_MIN) && (ppr_q <= eeo_pkg::EEO_PPR_MAX))
    else $error("pulse count out of range");

  a_ppr_clamp_high: assert property ( // [R2]
    @(posedge clk) disable iff (!rstn)
    (req && wb_we_i && widx == eeo_pkg::EEO_IDX_PPR && wb_sel_i[1:0] == 2'b11
     && wb_dat_i[15:0] > eeo_pkg::EEO_PPR_MAX)
    |=> ppr_q == eeo_pkg::EEO_PPR_MAX)
    else $error("large pulse count not clamped");

  a_ppr_clamp_low: assert property ( // [R2]
    @(posedge clk) disable iff (!rstn)
    (req && wb_we_i && widx == eeo_pkg::EEO_IDX_PPR
     && wr_ppr < eeo_pkg::EEO_PPR_MIN)
    |=> ppr_q == eeo_pkg::EEO_PPR_MIN)
    else $error("small pulse count not clamped");

  a_ppr_lands: assert property ( // [R2]
    @(posedge clk) disable iff (!rstn)
    (req && wb_we_i && widx == eeo_pkg::EEO_IDX_PPR
     && wr_ppr >= eeo_pkg::EEO_PPR_MIN && wr_ppr <= eeo_pkg::EEO_PPR_MAX)
    |=> ppr_q == $past(wr_ppr))
    else $error("legal pulse count not stored");

  a_offset_lands: assert property ( // [R5]
    @(posedge clk) disable iff (!rstn)
    (req && wb_we_i && widx == eeo_pkg::EEO_IDX_OFFSET)
    |=> offset_q == $past(wr_off))
    else $error("index offset not stored");

  a_step_one: assert property ( // [R1]
    @(posedge clk) disable iff (!rstn)
    ($past(ppr_q) == ppr_q && $past(cur_q) != eeo_pkg::EEO_Q_ZERO
     && cur_q != eeo_pkg::EEO_Q_ZERO)
    |-> (cur_q == $past(cur_q) || cur_q == $past(cur_q) + eeo_pkg::EEO_Q_ONE
         || cur_q == $past(cur_q) - eeo_pkg::EEO_Q_ONE))
    else $error("position jumped more than one step");

  a_count_range: assert property ( // [R1]
    @(posedge clk) disable iff (!rstn)
    (sensor == eeo_pkg::resolver_sensor_option
     && $past(sensor) == eeo_pkg::resolver_sensor_option && $stable(ppr_q))
    |-> cur13 < modulus)
    else $error("position past the end of the turn");

  // a new sensor type or pulse count may legally move both channels at once
  a_ab_quarter: assert property ( // [R11]
    @(posedge clk) disable iff (!rstn)
    (sensor == eeo_pkg::resolver_sensor_option && $stable(ctrl_q)
     && $past(ctrl_q, 2) == ctrl_q && $stable(ppr_q)
     && $past(ppr_q, 2) == ppr_q && $past(ppr_q, 3) == ppr_q)
    |-> !($changed(enc_q.a) && $changed(enc_q.b)))
    else $error("both channels changed together");

  a_resolver_ab: assert property ( // [R11]
    @(posedge clk) disable iff (!rstn)
    (sensor == eeo_pkg::resolver_sensor_option && enable)
    |=> enc_q.a == $past(cur_q[1]) && enc_q.b == $past(^cur_q[1:0]))
    else $error("channels not in quadrature with position");

  a_index_offset: assert property ( // [R5] [R7]
    @(posedge clk) disable iff (!rstn)
    (enc_q.z && $past(sensor) == eeo_pkg::resolver_sensor_option)
    |-> {1'b0, $past(cur_q)} == $past(off_quarter))
    else $error("index not at offset position");

  a_index_range: assert property ( // [R5]
    @(posedge clk) disable iff (!rstn)
    (enc_q.z && $past(sensor) == eeo_pkg::resolver_sensor_option)
    |-> $past(offset_q) < $past(ppr_q))
    else $error("index from an offset past the turn");

  a_no_index_sc: assert property ( // [R8]
    @(posedge clk) disable iff (!rstn)
    (sensor == eeo_pkg::sine_cosine_sensor_option
     || sensor == eeo_pkg::absolute_sensor_option) |=> !enc_q.z)
    else $error("index seen with sine-type sensor");

  a_hires_index: assert property ( // [R9]
    @(posedge clk) disable iff (!rstn)
    (sensor == eeo_pkg::hires_incremental_option && enable)
    |=> enc_q.z == $past(sensor_in.index))
    else $error("native index not passed through");

  a_sine_follow: assert property ( // [R4] [R3]
    @(posedge clk) disable iff (!rstn)
    (sensor != eeo_pkg::resolver_sensor_option && enable)
    |=> enc_q.a == $past(sensor_in.quad[1]) && $stable(cur_q))
    else $error("sine period not followed");

  a_sine_b: assert property ( // [R4]
    @(posedge clk) disable iff (!rstn)
    (sensor != eeo_pkg::resolver_sensor_option && enable)
    |=> enc_q.b == $past(^sensor_in.quad))
    else $error("second channel off the sine period");

  a_quiet_off: assert property (
    @(posedge clk) disable iff (!rstn)
    !enable |=> enc_q == '0)
    else $error("output active while disabled");

  a_ack_pulse: assert property (
    @(posedge clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_answer: assert property (
    @(posedge clk) disable iff (!rstn)
    req |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_rdat_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");

endmodule // eeo_encoder_emulation_output

// ==== verification/eeo_ctrl_model.sv ====
`timescale 1ns/1ps
module eeo_ctrl_model (
  input  wire logic              clk,
  input  wire logic              clr,
  input  wire eeo_pkg::eeo_enc_s enc,
  output int                     pos,
  output int                     n_idx,
  output int                     idx_pos,
  output int                     n_bad
);
  logic [1:0] ph_q;
  logic       z_q;
  logic [1:0] ph_d;
  logic [1:0] dph;
  int         stp;
  // binary phase decoded from gray-coded a/b, so each edge of either channel is one step
  assign ph_d = {enc.a, enc.a ^ enc.b};
  assign dph  = ph_d - ph_q;
  assign stp  = (dph == 2'h1) ? 1 : ((dph == 2'h3) ? -1 : 0);
  always_ff @(posedge clk) begin
    ph_q <= ph_d;
    z_q  <= enc.z;
    if (clr) begin
      pos   <= 0;
      n_idx <= 0;
      n_bad <= 0;
    end else begin
      pos   <= pos + stp;
      // a two-phase jump is an edge pair the counter cannot resolve
      n_bad <= n_bad + int'(dph == 2'h2);
      if (enc.z && !z_q) begin
        n_idx   <= n_idx + 1;
        idx_pos <= pos + stp;
      end
    end
  end
endmodule // eeo_ctrl_model

// ==== verification/encoder_emulation_output_tb.sv ====
`timescale 1ns/1ps
module encoder_emulation_output_tb;
  logic                clk;
  logic                rstn = 1'b0;
  logic [17:0]         adr  = 18'h0;
  logic [31:0]         wdat = 32'h0;
  logic [31:0]         rdat;
  logic                we   = 1'b0;
  logic [3:0]          sel  = 4'hF;
  logic [3:0]          msk  = 4'hF;
  logic                cyc  = 1'b0;
  logic                stb  = 1'b0;
  logic                ack;
  logic [15:0]         ang  = 16'h0;
  eeo_pkg::eeo_sense_s sens = '0;
  eeo_pkg::eeo_enc_s   enc;
  logic                clr  = 1'b0;
  int                  pos, n_idx, idx_pos, n_bad, p, o;
  int                  miscompares = 0;
  int                  num_checks  = 0;
  logic [31:0]         exp_q[$];

  eeo_encoder_emulation_output dut (
    .clk(clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .resolver_angle(ang),
    .sensor_in(sens), .enc_out(enc));
  eeo_ctrl_model ctrl (.clk(clk), .clr(clr), .enc(enc), .pos(pos),
    .n_idx(n_idx), .idx_pos(idx_pos), .n_bad(n_bad));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // master holds everything until the edge where ack is seen high
  task automatic wb(input logic w, input logic [15:0] i,
                    input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {i, 2'b00};
    wdat <= d;
    sel  <= msk;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, i, 32'h0);
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check("read data", exp_q.pop_front(), rdat);
    end
  end

  task automatic clear();
    clr <= 1'b1;
    repeat (3) @(posedge clk);
    clr <= 1'b0;
  endtask

  // 4 clocks per step keeps the target within reach of one step a clock
  task automatic turn(input int dir);
    for (int k = 0; k < 1024; k++) begin
      ang <= ang + 16'(dir * 64);
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h5276));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(eeo_pkg::EEO_IDX_OFFSET, 32'h0);
    rd(eeo_pkg::EEO_IDX_PPR, 32'h400);
    rd(16'h0100, 32'h0);
    rd(eeo_pkg::EEO_IDX_CTRL, 32'(eeo_pkg::EEO_CTRL_RST));
    rd(eeo_pkg::EEO_IDX_STAT, 32'h1 << eeo_pkg::EEO_STAT_Z_BIT);
    msk = 4'h2;
    wb(1'b1, eeo_pkg::EEO_IDX_PPR, 32'h0000_01FF);
    msk = 4'hF;
    rd(eeo_pkg::EEO_IDX_PPR, 32'h100);
    wb(1'b1, eeo_pkg::EEO_IDX_PPR, 32'h31);
    rd(eeo_pkg::EEO_IDX_PPR, 32'h32);
    wb(1'b1, eeo_pkg::EEO_IDX_PPR, 32'h401);
    rd(eeo_pkg::EEO_IDX_PPR, 32'h400);
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 50 : $urandom_range(1024, 51);
      o = $urandom_range(p - 1, 1);
      wb(1'b1, eeo_pkg::EEO_IDX_PPR, 32'(p));
      wb(1'b1, eeo_pkg::EEO_IDX_OFFSET, 32'(o));
      rd(eeo_pkg::EEO_IDX_OFFSET, 32'(o));
      clear();
      turn(1);
      check("pulses per turn", 32'(4 * p), pos);
      check("index count", 32'h1, n_idx);
      check("index place", 32'(4 * o), idx_pos);
      turn(-1);
      check("net pulses", 32'h0, pos);
      check("skipped edges", 32'h0, n_bad);
    end
    // sensor types other than resolver; angle noise must be ignored
    // the last pass runs the resolver with the outputs switched off
    for (int t = 1; t < 5; t++) begin
      wb(1'b1, eeo_pkg::EEO_IDX_CTRL, {29'h0, t != 4, 2'(t)});
      clear();
      for (int s = 1; s <= 12; s++) begin
        sens <= {2'(s), s == 6};
        ang  <= 16'($urandom);
        repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      check("sine pulses", (t == 4) ? 32'h0 : 32'd12, pos);
      check("native index", 32'(t == 2), n_idx);
      if (t == 2) begin
        check("native place", 32'd6, idx_pos);
      end
    end
    give_verdict();
  end
endmodule // encoder_emulation_output_tb
